// >>> pcs_checker.sv
// Purpose: Port-level checks of the chain sequencer's start, segment and ready behaviour
// Assumes: Single pclk domain, presetn active low
// Notes: Bound to every instance of the sequencer
`timescale 1ns/1ps
`default_nettype none
module pcs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic start,
  input wire logic [5:0] entry_select_inputs,
  input wire logic seg_done,
  input wire logic ready,
  input wire logic motion,
  input wire logic alarm,
  input wire logic seg_start,
  input wire logic [5:0] seg_entry,
  input wire logic [7:0] seg_accel,
  input wire logic [7:0] seg_decel,
  input wire logic seg_continue
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_resume;
    ##[1:40] (seg_start && motion);
  endsequence
  property p_take; start && ready |=> !ready && (seg_start || alarm); endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_sel; start && ready |=> !seg_start || seg_entry == $past(entry_select_inputs); endproperty
  a_sel: assert property (p_sel) else $error("wrong entry started");
  property p_idle; ready |-> !motion; endproperty
  a_idle: assert property (p_idle) else $error("moving while ready");
  property p_rdy; $rose(ready) |-> $past(seg_done) || $past(pready && pwrite); endproperty
  a_rdy: assert property (p_rdy) else $error("ready without cause");
  property p_link; seg_done && motion && seg_continue |=> (seg_start && motion) || alarm; endproperty
  a_link: assert property (p_link) else $error("link did not continue");
  property p_stop; seg_done && motion && !seg_continue |=> !motion && !seg_start; endproperty
  a_stop: assert property (p_stop) else $error("motor did not stop");
  property p_acc; seg_start && !$past(ready) |-> $stable(seg_accel) && $stable(seg_decel); endproperty
  a_acc: assert property (p_acc) else $error("ramp changed in chain");
  property p_dwell; $fell(motion) && !ready && !alarm |-> !ready throughout s_resume; endproperty
  a_dwell: assert property (p_dwell) else $error("dwell did not resume");
  property p_alm; $rose(alarm) |-> $past(start && ready) || $past(seg_done); endproperty
  a_alm: assert property (p_alm) else $error("alarm without cause");
endmodule // pcs_checker
bind pcs_sequencer pcs_checker i_chk (.*);
`default_nettype wire

// >>> pcs_pkg.sv
// Purpose: Shared constants and types for the positioning chain sequencer
// Assumes: APB slave with 32-bit data, clock pclk at 40 MHz
// Notes: Entry word layout and register offsets live here only
`default_nettype none

package pcs_pkg;

  // Clock and dwell time base
  localparam int CLK_PERIOD_PS = 25000;
  localparam int DWELL_UNIT_US = 1000;
  localparam int DWELL_TICK_CYCLES = (DWELL_UNIT_US * 1000) / CLK_PERIOD_PS;

  // Chain limits
  localparam int MAX_LINKED = 4;
  localparam logic [5:0] LAST_ENTRY = 6'h3F;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
  localparam logic [11:0] TABLE_BASE = 12'h100;
  localparam logic [11:0] TABLE_END = 12'h1FC;

  // Control bits
  localparam int CTRL_ALARM_RESET_BIT = 0;

  // Status bit positions
  localparam int ST_READY_BIT = 0;
  localparam int ST_MOTION_BIT = 1;
  localparam int ST_ALARM_BIT = 2;
  localparam int ST_DWELL_BIT = 3;
  localparam int ST_ENTRY_LSB = 8;
  localparam int ST_LINK_LSB = 16;

  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_LEN_ALARM_BIT = 1;
  localparam int EV_DIR_ALARM_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Entry word fields
  localparam int ENT_FUNC_LSB = 0;
  localparam int ENT_DIR_BIT = 2;
  localparam int ENT_ACC_LSB = 4;
  localparam int ENT_DEC_LSB = 12;
  localparam int ENT_DWELL_LSB = 20;
  localparam int ACC_W = 8;
  localparam int DWELL_W = 12;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PCS_FN_SINGLE = 2'h0,
    PCS_FN_LINKED = 2'h1,
    PCS_FN_DWELL_LINKED = 2'h2,
    PCS_FN_PUSH = 2'h3
  } pcs_func_t;

  typedef enum logic [3:0] {
    PCS_IDLE = 4'h1,
    PCS_RUN = 4'h2,
    PCS_DWELL = 4'h4,
    PCS_ALARM = 4'h8
  } pcs_state_t;

endpackage : pcs_pkg

`default_nettype wire

// >>> pcs_profile_model.sv
// Purpose: Profile generator stand-in that ends each segment with a one-cycle done pulse
// Assumes: lat is at least 1 while segments are running
// Notes: lat sets the segment length, so a run can be prompt or slow
`timescale 1ns/1ps
`default_nettype none
module pcs_profile_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic seg_start,
  input wire logic [3:0] lat,
  output logic seg_done
);
  typedef struct packed {logic [3:0] cnt; logic done;} pcs_prof_t;
  pcs_prof_t st, next_st;
  always_comb begin
    next_st = st;
    next_st.done = (st.cnt == 4'h1);
    if (seg_start) next_st.cnt = lat;
    else if (st.cnt != 4'h0) next_st.cnt = st.cnt - 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st <= '0;
    else st <= next_st;
  end
  assign seg_done = st.done;
endmodule // pcs_profile_model
`default_nettype wire

// >>> pcs_sequencer.sv
// Purpose: Positioning chain sequencer with APB register file and entry table
// Assumes: Host inputs synchronous to pclk; a profile generator answers seg_start with seg_done
// Notes: 64 operation entries, one word each, stored in this module
//
// What this block does
// - A single-motion entry runs exactly one move with its own data and then stops.
// - Ready drops when a start is accepted, and the host keeps start up until it sees that.
// - Ready returns once the whole operation, every chained segment included, is done, or when an alarm is reset through CTRL.
// - A linked-motion entry runs straight into the next entry's move without stopping the motor.
// - A chain ends at the first single-motion or push-motion entry, and the motor then stops.
// - At most four linked entries form one chain; five or more raise the data alarm at start.
// - Plain linked entries keep one direction; a reversal raises the data alarm while running.
// - Entry 63 never links onward to entry 0 and, set to linked or dwell-linked, runs as a single-motion entry.
// - A push-motion entry reached through a link runs at the starting speed.
// - A dwell-linked entry may reverse; the motor stops, waits the dwell time, then goes on.
// - Motion drops at the end of a dwell-linked segment and rises as the next one starts.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pcs_sequencer #(
  parameter int DWELL_TICK_CYCLES = pcs_pkg::DWELL_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start,
  input wire logic [5:0] entry_select_inputs,
  input wire logic seg_done,
  output logic ready,
  output logic motion,
  output logic alarm,
  output logic irq,
  output logic seg_start,
  output logic [5:0] seg_entry,
  output logic [7:0] seg_accel,
  output logic [7:0] seg_decel,
  output logic seg_continue,
  output logic seg_start_speed
);

  typedef struct packed {
    pcs_pkg::pcs_state_t state;
    logic [63:0][31:0] table_q;
    logic [5:0] cur;
    logic [2:0] link_cnt;
    logic [11:0] dwell_left;
    logic [15:0] tick;
    logic ready;
    logic motion;
    logic alarm;
    logic irq;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic seg_start;
    logic [5:0] seg_entry;
    logic [7:0] seg_accel;
    logic [7:0] seg_decel;
    logic seg_continue;
    logic seg_start_speed;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcs_regs_t;

  pcs_regs_t r;
  pcs_regs_t next_r;

  function automatic pcs_pkg::pcs_func_t ent_func(input logic [31:0] w);
    ent_func = pcs_pkg::pcs_func_t'(w[pcs_pkg::ENT_FUNC_LSB +: 2]);
  endfunction

  // Entry 63 behaves as a terminator whatever its function says
  function automatic logic ent_links(input logic [31:0] w, input logic [5:0] idx);
    pcs_pkg::pcs_func_t f;
    f = ent_func(w);
    ent_links = (f == pcs_pkg::PCS_FN_LINKED || f == pcs_pkg::PCS_FN_DWELL_LINKED)
                && (idx != pcs_pkg::LAST_ENTRY);
  endfunction

  // Counts linked entries from idx onward, stopping at the first terminator
  function automatic logic chain_too_long(input logic [63:0][31:0] tbl, input logic [5:0] idx);
    logic run;
    logic [6:0] pos;
    logic [2:0] cnt;
    run = 1'b1;
    pos = {1'b0, idx};
    cnt = 3'h0;
    for (int i = 0; i <= pcs_pkg::MAX_LINKED; i++) begin
      if (run && pos[6] == 1'b0 && ent_links(tbl[pos[5:0]], pos[5:0])) begin
        cnt = cnt + 3'h1;
        pos = pos + 7'h01;
      end else begin
        run = 1'b0;
      end
    end
    chain_too_long = (cnt > 3'(pcs_pkg::MAX_LINKED));
  endfunction

  function automatic logic is_table_addr(input logic [11:0] a);
    is_table_addr = (a >= pcs_pkg::TABLE_BASE) && (a <= pcs_pkg::TABLE_END);
  endfunction

  logic [5:0] nxt;
  logic [31:0] cur_w;
  logic [31:0] nxt_w;
  logic [2:0] ev;
  logic apb_wr;
  logic [5:0] sel_idx;

  always_comb begin
    next_r = r;
    ev = 3'h0;
    sel_idx = r.cur;
    cur_w = r.table_q[r.cur];
    nxt = r.cur + 6'h01;
    nxt_w = r.table_q[nxt];
    apb_wr = psel && penable && r.pready && pwrite;
    next_r.seg_start = 1'b0;

    // Sequencer
    case (r.state)
      pcs_pkg::PCS_IDLE: begin
        if (start && r.ready) begin
          sel_idx = entry_select_inputs;
          next_r.ready = 1'b0;
          next_r.cur = sel_idx;
          next_r.link_cnt = 3'h0;
          if (chain_too_long(r.table_q, sel_idx)) begin
            next_r.state = pcs_pkg::PCS_ALARM;
            next_r.alarm = 1'b1;
            ev[pcs_pkg::EV_LEN_ALARM_BIT] = 1'b1;
          end else begin
            next_r.state = pcs_pkg::PCS_RUN;
            next_r.motion = 1'b1;
            next_r.seg_start = 1'b1;
            next_r.seg_entry = sel_idx;
            next_r.seg_accel = r.table_q[sel_idx][pcs_pkg::ENT_ACC_LSB +: pcs_pkg::ACC_W];
            next_r.seg_decel = r.table_q[sel_idx][pcs_pkg::ENT_DEC_LSB +: pcs_pkg::ACC_W];
            next_r.seg_continue = ent_links(r.table_q[sel_idx], sel_idx)
              && ent_func(r.table_q[sel_idx]) == pcs_pkg::PCS_FN_LINKED;
            next_r.seg_start_speed = 1'b0;
          end
        end
      end
      pcs_pkg::PCS_RUN: begin
        if (seg_done) begin
          if (!ent_links(cur_w, r.cur)) begin
            next_r.state = pcs_pkg::PCS_IDLE;
            next_r.motion = 1'b0;
            next_r.ready = 1'b1;
            next_r.seg_continue = 1'b0;
            ev[pcs_pkg::EV_DONE_BIT] = 1'b1;
          end else if (ent_func(cur_w) == pcs_pkg::PCS_FN_DWELL_LINKED) begin
            next_r.state = pcs_pkg::PCS_DWELL;
            next_r.motion = 1'b0;
            next_r.dwell_left = cur_w[pcs_pkg::ENT_DWELL_LSB +: pcs_pkg::DWELL_W];
            next_r.tick = 16'h0000;
          end else if (nxt_w[pcs_pkg::ENT_DIR_BIT] != cur_w[pcs_pkg::ENT_DIR_BIT]) begin
            next_r.state = pcs_pkg::PCS_ALARM;
            next_r.alarm = 1'b1;
            next_r.motion = 1'b0;
            next_r.seg_continue = 1'b0;
            ev[pcs_pkg::EV_DIR_ALARM_BIT] = 1'b1;
          end else begin
            next_r.cur = nxt;
            next_r.link_cnt = r.link_cnt + 3'h1;
            next_r.seg_start = 1'b1;
            next_r.seg_entry = nxt;
            next_r.seg_continue = ent_links(nxt_w, nxt)
              && ent_func(nxt_w) == pcs_pkg::PCS_FN_LINKED;
            next_r.seg_start_speed = (ent_func(nxt_w) == pcs_pkg::PCS_FN_PUSH);
          end
        end
      end
      pcs_pkg::PCS_DWELL: begin
        if (r.dwell_left == 12'h000) begin
          next_r.state = pcs_pkg::PCS_RUN;
          next_r.motion = 1'b1;
          next_r.cur = nxt;
          next_r.link_cnt = r.link_cnt + 3'h1;
          next_r.seg_start = 1'b1;
          next_r.seg_entry = nxt;
          next_r.seg_continue = ent_links(nxt_w, nxt)
            && ent_func(nxt_w) == pcs_pkg::PCS_FN_LINKED;
          next_r.seg_start_speed = (ent_func(nxt_w) == pcs_pkg::PCS_FN_PUSH);
        end else if (r.tick == 16'(DWELL_TICK_CYCLES - 1)) begin
          next_r.tick = 16'h0000;
          next_r.dwell_left = r.dwell_left - 12'h001;
        end else begin
          next_r.tick = r.tick + 16'h0001;
        end
      end
      pcs_pkg::PCS_ALARM: begin
        next_r.motion = 1'b0;
        next_r.ready = 1'b0;
        if (apb_wr && paddr == pcs_pkg::CTRL_OFS && pwdata[pcs_pkg::CTRL_ALARM_RESET_BIT]) begin
          next_r.state = pcs_pkg::PCS_IDLE;
          next_r.alarm = 1'b0;
          next_r.ready = 1'b1;
        end
      end
      default: begin
        next_r.state = pcs_pkg::PCS_IDLE;
        next_r.ready = 1'b1;
        next_r.motion = 1'b0;
      end
    endcase

    // APB slave: one wait-free access phase, read data latched at setup
    next_r.pready = psel && !penable;
    if (psel && !penable) begin
      next_r.pslverr = !(is_table_addr(paddr) || paddr == pcs_pkg::CTRL_OFS
        || paddr == pcs_pkg::STATUS_OFS || paddr == pcs_pkg::IRQ_STATUS_OFS
        || paddr == pcs_pkg::IRQ_MASK_OFS) || paddr[1:0] != 2'h0;
      next_r.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (is_table_addr(paddr)) begin
          next_r.prdata = r.table_q[paddr[7:2]];
        end else if (paddr == pcs_pkg::STATUS_OFS) begin
          next_r.prdata[pcs_pkg::ST_READY_BIT] = r.ready;
          next_r.prdata[pcs_pkg::ST_MOTION_BIT] = r.motion;
          next_r.prdata[pcs_pkg::ST_ALARM_BIT] = r.alarm;
          next_r.prdata[pcs_pkg::ST_DWELL_BIT] = (r.state == pcs_pkg::PCS_DWELL);
          next_r.prdata[pcs_pkg::ST_ENTRY_LSB +: 6] = r.cur;
          next_r.prdata[pcs_pkg::ST_LINK_LSB +: 3] = r.link_cnt;
        end else if (paddr == pcs_pkg::IRQ_STATUS_OFS) begin
          next_r.prdata[pcs_pkg::IRQ_W-1:0] = r.irq_status;
        end else if (paddr == pcs_pkg::IRQ_MASK_OFS) begin
          next_r.prdata[pcs_pkg::IRQ_W-1:0] = r.irq_mask;
        end
      end
    end else if (!(psel && penable)) begin
      next_r.pslverr = 1'b0;
    end

    if (apb_wr && !r.pslverr) begin
      if (is_table_addr(paddr)) begin
        next_r.table_q[paddr[7:2]] = pwdata;
      end else if (paddr == pcs_pkg::IRQ_MASK_OFS) begin
        next_r.irq_mask = pwdata[pcs_pkg::IRQ_W-1:0];
      end
    end

    // Sticky events, write one to clear, a new event wins over the clear
    next_r.irq_status = r.irq_status;
    if (apb_wr && !r.pslverr && paddr == pcs_pkg::IRQ_STATUS_OFS) begin
      next_r.irq_status = r.irq_status & ~pwdata[pcs_pkg::IRQ_W-1:0];
    end
    next_r.irq_status = next_r.irq_status | ev;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state <= pcs_pkg::PCS_IDLE;
      r.table_q <= {64{pcs_pkg::ENTRY_RESET}};
      r.cur <= 6'h00;
      r.link_cnt <= 3'h0;
      r.dwell_left <= 12'h000;
      r.tick <= 16'h0000;
      r.ready <= 1'b1;
      r.motion <= 1'b0;
      r.alarm <= 1'b0;
      r.irq <= 1'b0;
      r.irq_status <= 3'h0;
      r.irq_mask <= pcs_pkg::IRQ_MASK_RESET;
      r.seg_start <= 1'b0;
      r.seg_entry <= 6'h00;
      r.seg_accel <= 8'h00;
      r.seg_decel <= 8'h00;
      r.seg_continue <= 1'b0;
      r.seg_start_speed <= 1'b0;
      r.prdata <= 32'h0000_0000;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign ready = r.ready;
  assign motion = r.motion;
  assign alarm = r.alarm;
  assign irq = r.irq;
  assign seg_start = r.seg_start;
  assign seg_entry = r.seg_entry;
  assign seg_accel = r.seg_accel;
  assign seg_decel = r.seg_decel;
  assign seg_continue = r.seg_continue;
  assign seg_start_speed = r.seg_start_speed;

endmodule // pcs_sequencer

`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the chain sequencer
// Assumes: Dwell tick shortened to 4 cycles
// Notes: Chains are table rows; reset, map and interrupt checks are hand written
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, start, seg_done, ready, motion, alarm, irq;
  logic seg_start, seg_continue, seg_start_speed, e, sp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] entry_select_inputs, seg_entry;
  logic [7:0] seg_accel, seg_decel;
  logic [3:0] lat;
  int fails, tests_run, segs;
  typedef struct packed {logic [5:0] sel; logic [31:0] segs; logic alm; logic sp;} pcs_row_t;
  typedef struct packed {logic [5:0] n; logic [31:0] w;} pcs_ent_t;
  pcs_row_t rows[8] = '{'{6'h01, 32'h1, 1'b0, 1'b0}, '{6'h02, 32'h2, 1'b0, 1'b0}, '{6'h05, 32'h2, 1'b0, 1'b0},
    '{6'h08, 32'h1, 1'b1, 1'b0}, '{6'h0A, 32'h0, 1'b1, 1'b0}, '{6'h0B, 32'h5, 1'b0, 1'b0},
    '{6'h3F, 32'h1, 1'b0, 1'b0}, '{6'h14, 32'h2, 1'b0, 1'b1}};
  pcs_ent_t ents[10] = '{'{6'h01, 32'h110}, '{6'h02, 32'h221}, '{6'h03, 32'h990}, '{6'h05, 32'h200002},
    '{6'h06, 32'h4}, '{6'h08, 32'h1}, '{6'h09, 32'h4}, '{6'h14, 32'h1}, '{6'h15, 32'h3}, '{6'h3F, 32'h1}};
  pcs_sequencer #(.DWELL_TICK_CYCLES(4)) i_dut (.*);
  pcs_profile_model i_prof (.*);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic test_done;
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Request stands until pready is seen high at a rising edge; data taken there
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin fails++; test_done(); end
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic run(input logic [5:0] s);
    int n;
    segs = 0; sp = 1'b0; n = 0;
    @(posedge pclk);
    start <= 1'b1; entry_select_inputs <= s;
    do begin @(negedge pclk); n++; if (seg_start === 1'b1) segs++; end while (ready !== 1'b0 && n < 20);
    @(posedge pclk);
    start <= 1'b0;
    n = 0;
    while (ready !== 1'b1 && alarm !== 1'b1 && n < 2000) begin
      @(negedge pclk); n++;
      if (seg_start === 1'b1) segs++;
      if (seg_start_speed === 1'b1) sp = 1'b1;
    end
    if (n >= 2000) begin fails++; test_done(); end
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    start = 1'b0; entry_select_inputs = '0; lat = 4'h3; fails = 0; tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pcs_pkg::STATUS_OFS, 32'h0); chk(q, 32'h1);
    apb(1'b0, pcs_pkg::IRQ_MASK_OFS, 32'h0); chk(q, 32'h0);
    apb(1'b0, 12'h010, 32'h0); chk({q[31:1], e}, 32'h1);
    for (int i = 10; i < 15; i++) apb(1'b1, pcs_pkg::TABLE_BASE + 12'(4 * i), (i == 12) ? 32'h100002 : 32'h1);
    foreach (ents[i]) apb(1'b1, pcs_pkg::TABLE_BASE + {4'h0, ents[i].n, 2'b00}, ents[i].w);
    foreach (rows[i]) begin
      apb(1'b1, pcs_pkg::CTRL_OFS, 32'h1);
      run(rows[i].sel);
      chk(32'(segs), rows[i].segs);
      chk({31'h0, alarm}, {31'h0, rows[i].alm});
      chk({31'h0, sp}, {31'h0, rows[i].sp});
    end
    apb(1'b1, pcs_pkg::CTRL_OFS, 32'h1);
    apb(1'b1, pcs_pkg::IRQ_STATUS_OFS, 32'h7);
    apb(1'b1, pcs_pkg::IRQ_MASK_OFS, 32'h1);
    lat <= 4'h9;
    run(6'h01); chk({31'h0, irq}, 32'h1);
    chk({26'h0, seg_entry}, 32'h1);
    chk({24'h0, seg_accel}, 32'h11);
    chk({31'h0, motion}, 32'h0);
    apb(1'b0, pcs_pkg::IRQ_STATUS_OFS, 32'h0); chk(q & 32'h1, 32'h1);
    apb(1'b1, pcs_pkg::IRQ_MASK_OFS, 32'h0); @(negedge pclk); chk({31'h0, irq}, 32'h0);
    apb(1'b1, pcs_pkg::IRQ_STATUS_OFS, 32'h1);
    apb(1'b0, pcs_pkg::IRQ_STATUS_OFS, 32'h0); chk(q & 32'h1, 32'h0);
    run(6'h02);
    chk({26'h0, seg_entry}, 32'h3);
    chk({24'h0, seg_accel}, 32'h22);
    chk({24'h0, seg_decel}, 32'h0);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
